// ---- common/cie_defines.vh ----
// Constants for the idle, increment, service-return and jump executor.
// How it works
// - Opcode 6F is a one-byte, four-cycle idle that stops the core clock enable, leaves the oscillator running and changes no flag.
// - An idle core wakes when an interrupt request arrives or when reset is applied.
// - Byte increment adds one in four cycles, with rE for a working register, 20 for a register address and 21 for register-indirect.
// - Both increments set zero, sign and overflow from the result and leave carry, decimal-adjust and half-carry alone.
// - Word increment adds one to an even-addressed byte pair taken as one 16-bit value, A0 for a pair and A1 indirect, two bytes and eight cycles.
// - Opcode BF normally pops flags, then a two-byte program counter, moves the stack pointer up by three and sets global interrupt enable, in twelve cycles.
// - With the fast-service flag set, BF loads PC from the thread pointer and that pointer with PC + 1, restores shadow flags and clears that flag, in six cycles.
// - Entering a fast interrupt exchanges the program counter with the thread pointer, so the handler address comes from it and the return address stays there.
// - The three-byte jump ccD takes eight cycles and loads the direct address when its condition holds, otherwise execution falls through.
// - The two-byte jump 30 takes eight cycles and loads the program counter from the register pair addressed by its operand.
// - In the first byte of the conditional jump the upper nibble is the condition code and the lower nibble the opcode.
// - Idle and both jumps leave every flag unchanged.
// - Bit zero of the system mode register is global interrupt enable and pending interrupts are only serviced while it is set.
`ifndef CIE_DEFINES_VH
`define CIE_DEFINES_VH

`define CIE_OP_IDLE       8'h6F
`define CIE_NIB_INC_R     4'hE
`define CIE_OP_INC_REG    8'h20
`define CIE_OP_INC_IND    8'h21
`define CIE_OP_ADD_ONE_WORD_PAIR  8'hA0
`define CIE_OP_ADD_ONE_WORD_IND   8'hA1
`define CIE_OP_SVC_RET    8'hBF
`define CIE_NIB_JP_COND   4'hD
`define CIE_OP_JP_PAIR    8'h30

`define CIE_CYC_IDLE      4'h4
`define CIE_CYC_INC       4'h4
`define CIE_CYC_ADD_ONE_WORD      4'h8
`define CIE_CYC_RET_NORM  4'hC
`define CIE_CYC_RET_FAST  4'h6
`define CIE_CYC_JUMP      4'h8

`define CIE_LEN_1         16'h0001
`define CIE_LEN_2         16'h0002
`define CIE_LEN_3         16'h0003

`define CIE_FLAG_C        7
`define CIE_FLAG_Z        6
`define CIE_FLAG_S        5
`define CIE_FLAG_V        4
`define CIE_FLAG_FAST     1
`define CIE_MODE_GIE      0

`define CIE_ADDR_PC_HI    4'h0
`define CIE_ADDR_PC_LO    4'h1
`define CIE_ADDR_SP       4'h2
`define CIE_ADDR_TP_HI    4'h3
`define CIE_ADDR_TP_LO    4'h4
`define CIE_ADDR_FLAGS    4'h5
`define CIE_ADDR_SHADOW   4'h6
`define CIE_ADDR_MODE     4'h7
`define CIE_ADDR_WRP      4'h8
`define CIE_ADDR_STATUS   4'h9
`define CIE_ADDR_RF_ADDR  4'hA
`define CIE_ADDR_RF_DATA  4'hB

`define CIE_RST_PC        16'h0000
`define CIE_RST_SP        8'h00
`define CIE_RST_BYTE      8'h00

`endif

// ---- rtl/cie_incr.v ----
// Adds one to a byte or a word and works out zero, sign and overflow.
`timescale 1ns/100ps
module cie_incr (
	// Operand and width select
	input  wire        word_sel,
	input  wire [15:0] value,
	// Result and flags
	output wire [15:0] result,
	output wire        zero,
	output wire        sign,
	output wire        ovfl
);
	wire [15:0] sum;

	assign sum    = value + 16'h0001;
	assign result = word_sel ? sum : {8'h00, sum[7:0]};
	// Flag results.
	// zero sign overflow
	assign zero   = word_sel ? (sum == 16'h0000) : (sum[7:0] == 8'h00);
	assign sign   = word_sel ? sum[15] : sum[7];
	assign ovfl   = word_sel ? (value == 16'h7FFF) : (value[7:0] == 8'h7F);
endmodule // cie_incr

// ---- rtl/cie_exec.v ----
// Executor for idle, byte and word increment, service return and jumps.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "cie_defines.vh"
module cie_exec (
	// Clock, reset, enable
	input  wire        CLOCK,
	input  wire        SRST,
	input  wire        CE,
	// Instruction issue
	input  wire        START,
	input  wire [7:0]  OP0,
	input  wire [7:0]  OP1,
	input  wire [7:0]  OP2,
	input  wire [15:0] COND_TRUE,
	input  wire [15:0] IRQ_VECTOR,
	// Interrupt pins
	input  wire        IRQ,
	input  wire        FAST_IRQ,
	// Register port
	input  wire [3:0]  ADDR,
	input  wire [7:0]  WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [7:0]  RDATA,
	// Status
	output reg         BUSY,
	output reg         DONE,
	output reg         ILLEGAL,
	output reg         CPU_CLK_EN,
	output reg  [15:0] PC
);
	localparam [2:0] ST_READY = 3'b001;
	localparam [2:0] ST_EXEC  = 3'b010;
	localparam [2:0] ST_IDLE  = 3'b100;

	reg  [7:0]  rf [0:255];
	reg  [2:0]  state_reg;
	reg  [3:0]  cnt_reg;
	reg  [7:0]  op0_reg;
	reg  [7:0]  op1_reg;
	reg  [7:0]  op2_reg;
	reg         fast_ret_reg;
	reg         cond_reg;
	reg  [7:0]  sp_reg;
	reg  [15:0] tp_reg;
	reg  [7:0]  flags_reg;
	reg  [7:0]  shadow_reg;
	reg  [7:0]  mode_reg;
	reg  [7:0]  wrp_reg;
	reg  [7:0]  rfa_reg;
	reg  [3:0]  cyc_next;
	reg         legal_next;
	reg  [7:0]  inc_addr;
	reg         inc_word;

	wire        irq_s;
	wire        fiq_s;
	wire [15:0] inc_val;
	wire [15:0] inc_res;
	wire        inc_z;
	wire        inc_s;
	wire        inc_v;
	wire [7:0]  pair_lo;
	wire [7:0]  flags_inc;
	wire        gie;
	wire [1:0]  irq_pins;
	wire [1:0]  sync_out;

	assign irq_pins = {FAST_IRQ, IRQ};
	// Only the second stage is read, so a metastable first stage has a full cycle to settle before it is used.
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_sync
			reg s1_reg;
			reg s2_reg;
			always @(posedge CLOCK) begin
				if (SRST) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else if (CE) begin
					s1_reg <= irq_pins[g];
					s2_reg <= s1_reg;
				end
			end
			assign sync_out[g] = s2_reg;
		end
	endgenerate
	assign irq_s = sync_out[0];
	assign fiq_s = sync_out[1];
	assign gie   = mode_reg[`CIE_MODE_GIE];

	// Cycle count and legality of the first byte.
	always @* begin
		cyc_next   = `CIE_CYC_INC;
		legal_next = 1'b1;
		if (OP0 == `CIE_OP_IDLE)
			cyc_next = `CIE_CYC_IDLE;
		else if (OP0[3:0] == `CIE_NIB_INC_R ||
		         OP0 == `CIE_OP_INC_REG || OP0 == `CIE_OP_INC_IND)
			cyc_next = `CIE_CYC_INC;
		else if (OP0 == `CIE_OP_ADD_ONE_WORD_PAIR || OP0 == `CIE_OP_ADD_ONE_WORD_IND)
			cyc_next = `CIE_CYC_ADD_ONE_WORD;
		else if (OP0 == `CIE_OP_SVC_RET)
			cyc_next = flags_reg[`CIE_FLAG_FAST] ? `CIE_CYC_RET_FAST :
			           `CIE_CYC_RET_NORM;
		else if (OP0[3:0] == `CIE_NIB_JP_COND || OP0 == `CIE_OP_JP_PAIR)
			cyc_next = `CIE_CYC_JUMP;
		else
			legal_next = 1'b0;
	end

	// Operand address for the increments.
	always @* begin
		inc_word = 1'b0;
		inc_addr = op1_reg;
		if (op0_reg[3:0] == `CIE_NIB_INC_R)
			inc_addr = {wrp_reg[7:4], op0_reg[7:4]};
		else if (op0_reg == `CIE_OP_INC_IND)
			inc_addr = rf[op1_reg];
		else if (op0_reg == `CIE_OP_ADD_ONE_WORD_PAIR) begin
			inc_word = 1'b1;
			inc_addr = {op1_reg[7:1], 1'b0};
		end else if (op0_reg == `CIE_OP_ADD_ONE_WORD_IND) begin
			inc_word = 1'b1;
			inc_addr = {rf[op1_reg][7:1], 1'b0};
		end
	end

	assign pair_lo = inc_addr | 8'h01;
	assign inc_val = inc_word ? {rf[inc_addr], rf[pair_lo]} :
	                 {8'h00, rf[inc_addr]};

	cie_incr u_incr (
		.word_sel (inc_word),
		.value    (inc_val),
		.result   (inc_res),
		.zero     (inc_z),
		.sign     (inc_s),
		.ovfl     (inc_v)
	);

	// Only zero, sign and overflow move; carry, D and H stay put.
	// keep other flags
	assign flags_inc = {flags_reg[7], inc_z, inc_s, inc_v, flags_reg[3:0]};

	always @(posedge CLOCK) begin
		if (SRST) begin
			state_reg    <= ST_READY;
			cnt_reg      <= 4'h0;
			op0_reg      <= `CIE_RST_BYTE;
			op1_reg      <= `CIE_RST_BYTE;
			op2_reg      <= `CIE_RST_BYTE;
			fast_ret_reg <= 1'b0;
			cond_reg     <= 1'b0;
			sp_reg       <= `CIE_RST_SP;
			tp_reg       <= `CIE_RST_PC;
			flags_reg    <= `CIE_RST_BYTE;
			shadow_reg   <= `CIE_RST_BYTE;
			mode_reg     <= `CIE_RST_BYTE;
			wrp_reg      <= `CIE_RST_BYTE;
			rfa_reg      <= `CIE_RST_BYTE;
			PC           <= `CIE_RST_PC;
			RDATA        <= `CIE_RST_BYTE;
			BUSY         <= 1'b0;
			DONE         <= 1'b0;
			ILLEGAL      <= 1'b0;
			CPU_CLK_EN   <= 1'b1;
		end else if (CE) begin
			DONE    <= 1'b0;
			ILLEGAL <= 1'b0;
			RDATA   <= `CIE_RST_BYTE;
			if (RD) begin
				case (ADDR)
				`CIE_ADDR_PC_HI:   RDATA <= PC[15:8];
				`CIE_ADDR_PC_LO:   RDATA <= PC[7:0];
				`CIE_ADDR_SP:      RDATA <= sp_reg;
				`CIE_ADDR_TP_HI:   RDATA <= tp_reg[15:8];
				`CIE_ADDR_TP_LO:   RDATA <= tp_reg[7:0];
				`CIE_ADDR_FLAGS:   RDATA <= flags_reg;
				`CIE_ADDR_SHADOW:  RDATA <= shadow_reg;
				`CIE_ADDR_MODE:    RDATA <= mode_reg;
				`CIE_ADDR_WRP:     RDATA <= wrp_reg;
				`CIE_ADDR_STATUS:  RDATA <= {5'h00, ~CPU_CLK_EN, BUSY,
				                             state_reg[0]};
				`CIE_ADDR_RF_ADDR: RDATA <= rfa_reg;
				`CIE_ADDR_RF_DATA: RDATA <= rf[rfa_reg];
				default:           RDATA <= `CIE_RST_BYTE;
				endcase
			end
			// Software writes first, so the core's own updates below win.
			if (WR) begin
				case (ADDR)
				`CIE_ADDR_PC_HI:   PC[15:8]     <= WDATA;
				`CIE_ADDR_PC_LO:   PC[7:0]      <= WDATA;
				`CIE_ADDR_SP:      sp_reg       <= WDATA;
				`CIE_ADDR_TP_HI:   tp_reg[15:8] <= WDATA;
				`CIE_ADDR_TP_LO:   tp_reg[7:0]  <= WDATA;
				`CIE_ADDR_FLAGS:   flags_reg    <= WDATA;
				`CIE_ADDR_SHADOW:  shadow_reg   <= WDATA;
				`CIE_ADDR_MODE:    mode_reg     <= WDATA;
				`CIE_ADDR_WRP:     wrp_reg      <= WDATA;
				`CIE_ADDR_RF_ADDR: rfa_reg      <= WDATA;
				`CIE_ADDR_RF_DATA: rf[rfa_reg]  <= WDATA;
				default:           rfa_reg      <= rfa_reg;
				endcase
			end
			case (state_reg)
			ST_READY: begin
				if (gie && fiq_s) begin
					PC         <= tp_reg;
					tp_reg     <= PC;
					shadow_reg <= flags_reg;
					flags_reg[`CIE_FLAG_FAST] <= 1'b1;
					mode_reg[`CIE_MODE_GIE]   <= 1'b0;
				end else if (gie && irq_s) begin
					// Normal entry stacks the frame that the return pops.
					rf[sp_reg - 8'h01] <= PC[7:0];
					rf[sp_reg - 8'h02] <= PC[15:8];
					rf[sp_reg - 8'h03] <= flags_reg;
					sp_reg  <= sp_reg - 8'h03;
					PC      <= IRQ_VECTOR;
					mode_reg[`CIE_MODE_GIE] <= 1'b0;
				end else if (START) begin
					if (legal_next) begin
						op0_reg      <= OP0;
						op1_reg      <= OP1;
						op2_reg      <= OP2;
						cnt_reg      <= cyc_next - 4'h1;
						fast_ret_reg <= flags_reg[`CIE_FLAG_FAST];
						cond_reg     <= COND_TRUE[OP0[7:4]];
						BUSY         <= 1'b1;
						state_reg    <= ST_EXEC;
					end else begin
						ILLEGAL <= 1'b1;
						DONE    <= 1'b1;
					end
				end
			end
			ST_EXEC: begin
				if (cnt_reg != 4'h0) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					BUSY      <= 1'b0;
					DONE      <= 1'b1;
					state_reg <= ST_READY;
					if (op0_reg == `CIE_OP_IDLE) begin
						PC         <= PC + `CIE_LEN_1;
						CPU_CLK_EN <= 1'b0;
						state_reg  <= ST_IDLE;
					end else if (op0_reg == `CIE_OP_SVC_RET) begin
						if (fast_ret_reg) begin
							PC        <= tp_reg;
							tp_reg    <= PC + `CIE_LEN_1;
							flags_reg <= shadow_reg;
							flags_reg[`CIE_FLAG_FAST] <= 1'b0;
						end else begin
							flags_reg <= rf[sp_reg];
							PC        <= {rf[sp_reg + 8'h01],
							              rf[sp_reg + 8'h02]};
							sp_reg    <= sp_reg + 8'h03;
							mode_reg[`CIE_MODE_GIE] <= 1'b1;
						end
					end else if (op0_reg == `CIE_OP_JP_PAIR) begin
						PC <= {rf[op1_reg], rf[op1_reg | 8'h01]};
					end else if (op0_reg[3:0] == `CIE_NIB_JP_COND) begin
						if (cond_reg)
							PC <= {op1_reg, op2_reg};
						else
							PC <= PC + `CIE_LEN_3;
					end else begin
						if (inc_word) begin
							rf[inc_addr] <= inc_res[15:8];
							rf[pair_lo]  <= inc_res[7:0];
						end else begin
							rf[inc_addr] <= inc_res[7:0];
						end
						flags_reg <= flags_inc;
						PC <= (op0_reg[3:0] == `CIE_NIB_INC_R) ?
						      PC + `CIE_LEN_1 : PC + `CIE_LEN_2;
					end
				end
			end
			ST_IDLE: begin
				if (irq_s || fiq_s) begin
					CPU_CLK_EN <= 1'b1;
					state_reg  <= ST_READY;
				end
			end
			default: state_reg <= ST_READY;
			endcase
		end
	end
endmodule // cie_exec

// ---- dv/cie_exec_asserts.sv ----
// Port-level assertions for the instruction executor.
`timescale 1ns/100ps
module cie_exec_asserts (
	// Clock, reset and enable
	input wire        CLOCK,
	input wire        SRST,
	input wire        CE,
	// Issue inputs
	input wire [7:0]  OP0,
	input wire [7:0]  OP1,
	input wire [7:0]  OP2,
	input wire [15:0] COND_TRUE,
	input wire        IRQ,
	// Status outputs
	input wire        BUSY,
	input wire        DONE,
	input wire        CPU_CLK_EN,
	input wire [15:0] PC
);
	reg [7:0] op0_d;
	reg       cond_d;
	always @(posedge CLOCK) begin
		op0_d <= OP0;
		cond_d <= COND_TRUE[OP0[7:4]];
	end
	default clocking dc @(posedge CLOCK); endclocking
	// Any check that spans a frozen cycle is abandoned, not resumed, since all state simply holds then.
	default disable iff (SRST || !CE);
	idle_length_a: assert property ($rose(BUSY) && op0_d == 8'h6F
		|-> BUSY[*4] ##1 (DONE && !BUSY && !CPU_CLK_EN))
		else $error("idle length wrong");
	idle_wake_a: assert property (!CPU_CLK_EN && IRQ
		|-> ##[1:4] CPU_CLK_EN)
		else $error("idle core did not wake");
	byte_inc_len_a: assert property ($rose(BUSY) && (op0_d == 8'h20
		|| op0_d == 8'h21 || op0_d[3:0] == 4'hE)
		|-> BUSY[*4] ##1 (DONE && !BUSY)) else $error("inc length wrong");
	word_inc_len_a: assert property ($rose(BUSY)
		&& (op0_d == 8'hA0 || op0_d == 8'hA1)
		|-> BUSY[*8] ##1 (DONE && !BUSY)) else $error("add_one_word length wrong");
	ret_length_a: assert property ($rose(BUSY) && op0_d == 8'hBF
		|-> BUSY[*6] ##1 ((DONE && !BUSY)
		or (BUSY[*6] ##1 (DONE && !BUSY))))
		else $error("return length wrong");
	jump_length_a: assert property ($rose(BUSY)
		&& (op0_d[3:0] == 4'hD || op0_d == 8'h30)
		|-> BUSY[*8] ##1 (DONE && !BUSY)) else $error("jump length wrong");
	jump_taken_a: assert property ($rose(BUSY) && op0_d[3:0] == 4'hD
		&& cond_d |-> ##8 PC == {$past(OP1, 9), $past(OP2, 9)})
		else $error("taken jump target wrong");
	jump_fallthru_a: assert property ($rose(BUSY) && op0_d[3:0] == 4'hD
		&& !cond_d |-> ##8 PC == $past(PC, 9) + 16'h0003)
		else $error("untaken jump did not fall through");
endmodule // cie_exec_asserts

bind cie_exec cie_exec_asserts u_chk (.*);

// ---- dv/cie_exec_test.sv ----
// Self-checking bench for the instruction executor.
`timescale 1ns/100ps
module cie_exec_test;
	reg        CLOCK = 1'b0, SRST = 1'b1, START = 1'b0, IRQ = 1'b0;
	reg        FAST_IRQ = 1'b0, WR = 1'b0, RD = 1'b0, rd_d = 1'b0;
	reg        CE = 1'b1;
	reg [15:0] IRQ_VECTOR = 16'h0ABC;
	integer    stall = 0;
	reg [3:0]  ADDR = 4'h0;
	reg [7:0]  OP0 = 8'h00, OP1 = 8'h00, OP2 = 8'h00, WDATA = 8'h00, v, r, f;
	reg [15:0] COND_TRUE = 16'h0000, exp_pc = 16'h0000, cnt = 16'h0000, cnd;
	reg [23:0] lst = 24'hC7_5210, ops = 24'h21_1E20, arg = 24'h50_0040;
	reg [31:0] seed = 32'h17f8, e;
	reg [7:0]  rd_q[$];
	reg [31:0] ex_q[$];
	wire [7:0] RDATA;
	wire       BUSY, DONE, ILLEGAL, CPU_CLK_EN;
	wire [15:0] PC;
	integer    err_total = 0, n_compared = 0, cycles = 0, i, k;
	always #25 CLOCK = ~CLOCK;
	cie_exec DUT (.CLOCK(CLOCK), .SRST(SRST), .CE(CE), .START(START),
		.OP0(OP0), .OP1(OP1), .OP2(OP2), .COND_TRUE(COND_TRUE),
		.IRQ_VECTOR(IRQ_VECTOR), .IRQ(IRQ), .FAST_IRQ(FAST_IRQ),
		.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL),
		.CPU_CLK_EN(CPU_CLK_EN), .PC(PC));
	task test_done;
		begin
			$display("compared %0d, wrong %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] want);
		begin
			n_compared = n_compared + 1;
			if (got !== want) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: %h not %h", $time, got, want);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(posedge CLOCK);
			ADDR <= a;
			WDATA <= d;
			WR <= 1'b1;
			@(posedge CLOCK);
			WR <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] want);
		begin
			@(posedge CLOCK);
			ADDR <= a;
			RD <= 1'b1;
			rd_q.push_back(want);
			@(posedge CLOCK);
			RD <= 1'b0;
		end
	endtask
	task rf_set(input [7:0] a, input [7:0] d);
		begin
			wr(4'hA, a);
			wr(4'hB, d);
		end
	endtask
	// Notes cycle count and program counter, then waits for completion.
	task ex(input [7:0] o0, input [7:0] o1, input [7:0] o2, input [15:0] n);
		begin
			@(posedge CLOCK);
			START <= 1'b1;
			OP0 <= o0;
			OP1 <= o1;
			OP2 <= o2;
			ex_q.push_back({n, exp_pc});
			@(posedge CLOCK);
			START <= 1'b0;
			// A stall freezes the core, so the expected count includes it.
			if (stall != 0) begin
				CE <= 1'b0;
				repeat (stall) @(posedge CLOCK);
				CE <= 1'b1;
			end
			k = 0;
			while (DONE !== 1'b1 && k < 40) begin
				@(posedge CLOCK);
				k = k + 1;
			end
			if (DONE !== 1'b1) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: no completion", $time);
			end
		end
	endtask
	always @(posedge CLOCK) begin
		cycles = cycles + 1;
		rd_d <= RD;
		cnt <= (START && !BUSY) ? 16'h0000 : cnt + 16'h0001;
		if (rd_d)
			chk({8'h00, RDATA}, {8'h00, rd_q.pop_front()});
		if (DONE === 1'b1) begin
			e = ex_q.pop_front();
			chk(cnt, e[31:16]);
			chk(PC, e[15:0]);
			chk({15'h0000, ILLEGAL}, {15'h0000, e[31:16] == 16'h0000});
		end
		if (cycles == 20000) begin
			err_total = err_total + 1;
			test_done;
		end
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		SRST <= 1'b0;
		for (i = 0; i < 6; i = i + 1)
			rd(lst[4 * i +: 4], 8'h00);
		wr(4'h8, 8'h40);
		rf_set(8'h50, 8'h42);
		for (i = 0; i < 3; i = i + 1) begin
			v = (i == 0) ? 8'h7F : (i == 1) ? 8'hFF : $random(seed);
			r = v + 8'h01;
			f = {1'b1, v == 8'hFF, r[7], v == 8'h7F, 4'h0};
			wr(4'h5, 8'h80);
			rf_set(8'h40 | i[7:0], v);
			exp_pc = exp_pc + ((i == 1) ? 16'h0001 : 16'h0002);
			ex(ops[8 * i +: 8], arg[8 * i +: 8], 8'h00, 16'h0004);
			wr(4'hA, 8'h40 | i[7:0]);
			rd(4'hB, r);
			rd(4'h5, f);
		end
		wr(4'h5, 8'h00);
		rf_set(8'h60, 8'h7F);
		rf_set(8'h61, 8'hFF);
		rf_set(8'h70, 8'h60);
		for (i = 0; i < 2; i = i + 1) begin
			exp_pc = exp_pc + 16'h0002;
			ex(i ? 8'hA1 : 8'hA0, i ? 8'h70 : 8'h61, 8'h00, 16'h0008);
			wr(4'hA, 8'h61);
			rd(4'hB, i[7:0]);
			rd(4'h5, i ? 8'h20 : 8'h30);
		end
		wr(4'h5, 8'hF0);
		exp_pc = exp_pc + 16'h0001;
		ex(8'h6F, 8'h00, 8'h00, 16'h0004);
		chk({15'h0000, CPU_CLK_EN}, 16'h0000);
		IRQ <= 1'b1;
		repeat (6) @(posedge CLOCK);
		IRQ <= 1'b0;
		chk({15'h0000, CPU_CLK_EN}, 16'h0001);
		for (i = 0; i < 16; i = i + 1) begin
			cnd = $random(seed);
			COND_TRUE <= cnd;
			exp_pc = cnd[i] ? 16'h5A5A : exp_pc + 16'h0003;
			ex({i[3:0], 4'hD}, 8'h5A, 8'h5A, 16'h0008);
		end
		rf_set(8'h80, 8'h12);
		rf_set(8'h81, 8'h34);
		exp_pc = 16'h1234;
		stall = 3;
		ex(8'h30, 8'h80, 8'h00, 16'h000B);
		stall = 0;
		rd(4'h5, 8'hF0);
		wr(4'h2, 8'h90);
		rf_set(8'h90, 8'h40);
		rf_set(8'h91, 8'h22);
		rf_set(8'h92, 8'h33);
		exp_pc = 16'h2233;
		ex(8'hBF, 8'h00, 8'h00, 16'h000C);
		rd(4'h2, 8'h93);
		rd(4'h7, 8'h01);
		rd(4'h5, 8'h40);
		wr(4'h3, 8'h04);
		wr(4'h4, 8'h56);
		wr(4'h6, 8'h10);
		wr(4'h5, 8'h02);
		exp_pc = 16'h0456;
		ex(8'hBF, 8'h00, 8'h00, 16'h0006);
		rd(4'h5, 8'h10);
		rd(4'h4, 8'h34);
		wr(4'h7, 8'h01);
		FAST_IRQ <= 1'b1;
		repeat (6) @(posedge CLOCK);
		FAST_IRQ <= 1'b0;
		chk(PC, 16'h2234);
		rd(4'h4, 8'h56);
		rd(4'h7, 8'h00);
		exp_pc = 16'h2234;
		ex(8'h00, 8'h00, 8'h00, 16'h0000);
		// Normal entry stacks a frame that the normal return then pops.
		wr(4'h5, 8'h00);
		wr(4'h7, 8'h01);
		IRQ <= 1'b1;
		repeat (6) @(posedge CLOCK);
		IRQ <= 1'b0;
		chk(PC, 16'h0ABC);
		rd(4'h2, 8'h90);
		ex(8'hBF, 8'h00, 8'h00, 16'h000C);
		rd(4'h2, 8'h93);
		rd(4'h7, 8'h01);
		exp_pc = 16'h2235;
		ex(8'h6F, 8'h00, 8'h00, 16'h0004);
		chk({15'h0000, CPU_CLK_EN}, 16'h0000);
		SRST <= 1'b1;
		repeat (2) @(posedge CLOCK);
		SRST <= 1'b0;
		chk({15'h0000, CPU_CLK_EN}, 16'h0001);
		chk(PC, 16'h0000);
		@(posedge CLOCK);
		chk(ex_q.size(), 16'h0000);
		chk(rd_q.size(), 16'h0000);
		test_done;
	end
endmodule // cie_exec_test
